// file: logic/acs_regs.svh
// Purpose: named constants of the calibration sequencer
// Assumes: counts are master-clock cycles
// Notes:   durations are cycle figures, so no time conversion is needed
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_WORD_W        20
`define ACS_CNT_W         22
`define ACS_MIN_HIGH      3'h4
`define ACS_SEL_SELF      2'h0
`define ACS_SEL_GAIN      2'h1
`define ACS_SEL_OFFS_REF  2'h2
`define ACS_SEL_OFFS      2'h3
`define ACS_CNT_LAST      22'h000001
`define ACS_CYC_SELF      22'd3145655
`define ACS_CYC_OFFS      22'd1052599
`define ACS_CYC_GAIN      22'd1068813
`define ACS_CYC_OFFS_REF  22'd2117389
`define ACS_WORD_ZERO     20'h00000
`define ACS_WORD_ONES     20'hfffff
`define ACS_BIP_FLIP      20'h80000

`endif

// file: logic/acs_pkg.sv
// Purpose: types of the calibration sequencer
// Assumes: nothing
// Notes:   select code packs cal_select_a in bit 1, cal_select_b in bit 0
`default_nettype none
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_IDLE,
      ACS_ARMED,
      ACS_RUN
   } acs_state_t;

   typedef struct packed {
      logic cal_select_a;
      logic cal_select_b;
   } acs_sel_t;
endpackage : acs_pkg
`default_nettype wire

// file: logic/acs_sequencer.sv
// Purpose: calibration control sequencer of a 20-bit sigma-delta converter
// Assumes: request, select and polarity pins asynchronous to i_core_clk, synchronised by two flops
// Notes:   i_core_clk stands for master_clock_in
// Behaviour
// - select inputs captured at rising edge of calibrate request
// - calibration step starts at falling edge of request
// - data_ready_n high from step start until step finishes
// - select code picks step type and its cycle duration
// - self calibration lasts at most 3,145,655 cycles
// - self calibration ends with input word and data_ready_n low
// - system step ends with all zeros or all ones word
// - after system step data_ready_n falls as filter settling begins
// - polarity low is unipolar range, high is bipolar range
// - straight binary in unipolar, offset binary in bipolar
`timescale 1ns/100ps
`default_nettype none
`include "acs_regs.svh"
module acs_sequencer #(
   parameter int unsigned WORD_W = `ACS_WORD_W,
   parameter logic [`ACS_CNT_W-1:0] CYC_SELF     = `ACS_CYC_SELF,
   parameter logic [`ACS_CNT_W-1:0] CYC_OFFS     = `ACS_CYC_OFFS,
   parameter logic [`ACS_CNT_W-1:0] CYC_GAIN     = `ACS_CYC_GAIN,
   parameter logic [`ACS_CNT_W-1:0] CYC_OFFS_REF = `ACS_CYC_OFFS_REF
) (
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_reset_n,
   // calibration control pins
   input  wire logic              i_cal_request,
   input  wire logic              i_cal_select_a,
   input  wire logic              i_cal_select_b,
   input  wire logic              i_polarity_select,
   // converted sample from the filter, straight binary, 0 = zero scale
   input  wire logic [WORD_W-1:0] i_sample,
   // status and output word
   output logic                   o_data_ready_n,
   output logic                   o_busy,
   output logic [WORD_W-1:0]      o_data_word
);

   // two-flop synchronisers; stage 1 is read only by stage 2
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic       req_prev;
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         sync1    <= 4'h0;
         sync2    <= 4'h0;
         req_prev <= 1'b0;
      end else begin
         sync1    <= {i_polarity_select, i_cal_select_a, i_cal_select_b, i_cal_request};
         sync2    <= sync1;
         req_prev <= sync2[0];
      end
   end

   wire       req      = sync2[0];
   wire       req_rise = req & ~req_prev;
   wire       req_fall = ~req & req_prev;
   wire       bipolar  = sync2[3];
   acs_pkg::acs_sel_t sel_now;
   assign sel_now.cal_select_a = sync2[2];
   assign sel_now.cal_select_b = sync2[1];

   function automatic logic [`ACS_CNT_W-1:0] step_cycles(input logic [1:0] code);
      case (code)
         `ACS_SEL_SELF:     step_cycles = CYC_SELF;
         `ACS_SEL_OFFS:     step_cycles = CYC_OFFS;
         `ACS_SEL_GAIN:     step_cycles = CYC_GAIN;
         default:           step_cycles = CYC_OFFS_REF;
      endcase
   endfunction

   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   acs_pkg::acs_sel_t   sel;
   logic [2:0]          high_cnt;
   logic [`ACS_CNT_W-1:0] cnt;

   // a request shorter than the minimum high time is dropped rather than started
   wire high_ok = (high_cnt >= `ACS_MIN_HIGH);
   wire start   = (state == acs_pkg::ACS_ARMED) & req_fall & high_ok;
   wire done    = (state == acs_pkg::ACS_RUN) & (cnt == `ACS_CNT_LAST);

   always_comb begin
      next_state = state;
      case (state)
         acs_pkg::ACS_IDLE:  if (req_rise) next_state = acs_pkg::ACS_ARMED;
         acs_pkg::ACS_ARMED: if (req_fall) next_state = high_ok ? acs_pkg::ACS_RUN
                                                                : acs_pkg::ACS_IDLE;
         acs_pkg::ACS_RUN:   if (done) next_state = acs_pkg::ACS_IDLE;
         default:            next_state = acs_pkg::ACS_IDLE;
      endcase
   end

   // output word on completion
   wire [1:0]        code      = {sel.cal_select_a, sel.cal_select_b};
   wire [WORD_W-1:0] coded_in  = bipolar ? (i_sample ^ `ACS_BIP_FLIP) : i_sample;
   wire [WORD_W-1:0] done_word = (code == `ACS_SEL_SELF) ? coded_in
                               : (code == `ACS_SEL_GAIN) ? `ACS_WORD_ONES
                               : `ACS_WORD_ZERO;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         state    <= acs_pkg::ACS_IDLE;
         sel      <= '0;
         high_cnt <= 3'h0;
         cnt      <= '0;
      end else begin
         state <= next_state;
         if (state == acs_pkg::ACS_IDLE && req_rise) begin
            sel      <= sel_now;
            high_cnt <= 3'h1;
         end else if (state == acs_pkg::ACS_ARMED && req && !high_ok) begin
            high_cnt <= high_cnt + 3'h1;
         end
         if (start) begin
            cnt <= step_cycles({sel.cal_select_a, sel.cal_select_b});
         end else if (state == acs_pkg::ACS_RUN) begin
            cnt <= cnt - `ACS_CNT_LAST;
         end
      end
   end

   // ready stays high from power-up until the first calibration completes
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_data_ready_n <= 1'b1;
         o_data_word    <= '0;
      end else if (start) begin
         o_data_ready_n <= 1'b1;
      end else if (done) begin
         o_data_ready_n <= 1'b0;
         o_data_word    <= done_word;
      end
   end

   assign o_busy = (state == acs_pkg::ACS_RUN);

endmodule : acs_sequencer
`default_nettype wire

// file: tb/acs_props.sv
// Purpose: port checker of acs_sequencer
// Assumes: MAXN is the longest step
// Notes:   reset low disables all
`timescale 1ns/100ps
`default_nettype none
module acs_props #(parameter int MAXN = 20) (
   // watched ports
   input wire logic        i_core_clk,
   input wire logic        i_reset_n,
   input wire logic        i_cal_request,
   input wire logic        o_data_ready_n,
   input wire logic        o_busy,
   input wire logic [19:0] o_data_word
);
   // busy cycles so far; a counter because real step lengths exceed any delay range
   logic [21:0] run_cnt;
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n || !o_busy) run_cnt <= 22'h0;
      else run_cnt <= run_cnt + 22'h1;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   busy_data_ready_n_a: assert property (o_busy |-> o_data_ready_n) else $error("data_ready_n");
   data_ready_n_hold_a: assert property (!o_data_ready_n |=> !o_data_ready_n || o_busy) else $error("hold");
   data_ready_n_rise_a: assert property ($rose(o_data_ready_n) |-> o_busy) else $error("rise");
   done_data_ready_n_a: assert property ($fell(o_busy) |-> !o_data_ready_n) else $error("done");
   word_load_a: assert property ($changed(o_data_word) |-> $fell(o_busy)) else $error("word");
   start_fall_a: assert property ($rose(o_busy) |-> !$past(i_cal_request)) else $error("start");
   step_min_a: assert property ($rose(o_busy) |-> o_busy [*8]) else $error("min");
   step_max_a: assert property (o_busy |-> run_cnt < MAXN) else $error("max");
   cover property ($rose(o_busy));
   cover property ($fell(o_busy));
   cover property (o_busy && i_cal_request);
endmodule : acs_props
bind acs_sequencer acs_props #(.MAXN(CYC_SELF)) u_props (.i_core_clk(i_core_clk),
   .i_reset_n(i_reset_n), .i_cal_request(i_cal_request), .o_data_ready_n(o_data_ready_n),
   .o_busy(o_busy), .o_data_word(o_data_word));
`default_nettype wire

// file: tb/acs_host_model.sv
// Purpose: controller driving the calibration pins
// Assumes: one pulse at a time unless forked
// Notes:   hold below four only to test refusal
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
   input  wire logic i_core_clk,
   output var logic  o_cal_request,
   output var logic  o_cal_select_a,
   output var logic  o_cal_select_b,
   output var logic  o_polarity_select
);
   initial {o_cal_request, o_cal_select_a, o_cal_select_b, o_polarity_select} = 4'h0;
   task pulse(input logic [1:0] code, input logic pol, input int hold);
      @(posedge i_core_clk);
      {o_cal_select_a, o_cal_select_b} <= code;
      o_polarity_select <= pol;
      @(posedge i_core_clk);
      o_cal_request <= 1'h1;
      repeat (hold) @(posedge i_core_clk);
      o_cal_request <= 1'h0;
   endtask : pulse
endmodule : acs_host_model
`default_nettype wire

// file: tb/acs_sequencer_tb.sv
// Purpose: self-checking bench of acs_sequencer
// Assumes: short step counts 20, 8, 9, 15
// Notes:   outputs sampled at falling edges
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_tb;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [19:0] sample = 20'h0;
   wire logic   req, sa, sb, pol, data_ready_n_n, busy;
   wire logic [19:0] word;
   int          num_errors = 0;
   int          num_checks = 0;
   int          dur[4] = '{20, 9, 15, 8};
   logic [1:0]  seq[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
   always #25 clk = ~clk;
   acs_host_model host (.i_core_clk(clk), .o_cal_request(req), .o_cal_select_a(sa),
      .o_cal_select_b(sb), .o_polarity_select(pol));
   acs_sequencer #(.CYC_SELF(22'h14), .CYC_OFFS(22'h8), .CYC_GAIN(22'h9), .CYC_OFFS_REF(22'hf))
   DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_cal_request(req), .i_cal_select_a(sa),
      .i_cal_select_b(sb), .i_polarity_select(pol), .i_sample(sample),
      .o_data_ready_n(data_ready_n_n), .o_busy(busy), .o_data_word(word));
   task chk(input logic [21:0] seen, input logic [21:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // one step; inj fires a second request mid-step, which must change nothing
   task step(input logic [1:0] code, input logic p, input logic inj);
      int n;
      n = 0;
      @(posedge clk);
      sample <= 20'($urandom);
      host.pulse(code, p, 4 + $urandom % 4);
      while (busy !== 1'h1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk(busy, 1'h1);
      if (inj) fork host.pulse(2'h1, p, 4); join_none
      n = 0;
      while (busy === 1'h1 && n < 30) begin
         n++;
         @(negedge clk);
      end
      chk(22'(n), 22'(dur[code]));
      chk(data_ready_n_n, 1'h0);
      chk(word, code == 2'h1 ? 20'hfffff : code != 2'h0 ? 20'h0 : sample ^ {p, 19'h0});
   endtask : step
   initial begin
      void'($urandom(32'h3d51));
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      chk({busy, data_ready_n_n, word}, 22'h100000);
      for (int i = 0; i < 8; i++) step(seq[i % 4], i[2], 1'h0);
      host.pulse(2'h0, 1'h0, 2);
      repeat (10) @(negedge clk);
      chk(busy, 1'h0);
      step(2'h0, 1'h1, 1'h1);
      tally_and_finish();
   end
   initial begin
      repeat (2000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
endmodule : acs_sequencer_tb
`default_nettype wire
